// ==== src/ulsr_status.sv ====
// Receive line status flags, receive buffer, spare storage byte and APB register slave.
`timescale 1ns/100ps

// Functional notes
// - Parity error flag sets on a bad-parity character only with parity checking enabled.
// - In FIFO mode parity error shows when the character reaches the FIFO head.
// - A detected break also sets the parity error flag.
// - Reading the line status register clears the parity error flag.
// - Without FIFO, a character arriving before the buffer is read sets overrun.
// - Without FIFO, the unread buffer is overwritten by the new character.
// - With FIFO, a character arriving while the FIFO is full sets overrun.
// - On FIFO overrun the FIFO keeps its contents; the new character is dropped.
// - Reading the line status register clears the overrun flag.
// - Data available is high while a character waits in buffer or FIFO.
// - Data available clears on buffer read, or when the FIFO empties.
// - An 8-bit read/write spare storage byte, reset zero, with no side effects.
// - FIFO mode is active while the FIFO enable control bit is one.
// - A break is a serial low lasting longer than one whole character.
module ulsr_status
  import ulsr_pkg::*;
#(
  parameter int FIFO_DEPTH  = ULSR_FIFO_DEPTH,
  parameter int BREAK_LIMIT = ULSR_BREAK_LIMIT
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_arst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Receive shifter
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_parity_bad,
  input  wire logic        i_rx_serial,
  // Status
  output logic             o_data_available,
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [1:0]               control_reg;
  logic [7:0]               spare_reg;
  ulsr_char_t               rbr_reg;
  logic                     rbr_full_reg;
  logic                     parity_err_reg;
  logic                     overrun_reg;
  logic                     break_reg;
  logic                     head_shown_reg;
  logic [ULSR_EV_WIDTH-1:0] int_status_reg;
  logic [ULSR_EV_WIDTH-1:0] int_enable_reg;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // One wait state: the first access cycle captures read data, the second completes.
  wire access   = i_psel & i_penable;
  wire done     = access & o_pready;
  wire wr_done  = done & i_pwrite;
  wire rd_done  = done & ~i_pwrite;
  wire hit_buf  = (i_paddr == ULSR_RX_BUFFER_ADDR);
  wire hit_ctl  = (i_paddr == ULSR_CONTROL_ADDR);
  wire hit_ist  = (i_paddr == ULSR_INT_STATUS_ADDR);
  wire hit_icl  = (i_paddr == ULSR_INT_CLEAR_ADDR);
  wire hit_ien  = (i_paddr == ULSR_INT_ENABLE_ADDR);
  wire hit_lsr  = (i_paddr == ULSR_LINE_STAT_ADDR);
  wire hit_spr  = (i_paddr == ULSR_SPARE_ADDR);
  wire hit_any  = hit_buf | hit_ctl | hit_ist | hit_icl | hit_ien | hit_lsr | hit_spr;
  wire pready_next = access & ~o_pready;

  wire fifo_mode  = control_reg[ULSR_CTL_FIFO_EN_BIT];
  wire parity_en  = control_reg[ULSR_CTL_PARITY_EN_BIT];

  // ----------------------------------------------------------------
  // Character arrival and FIFO
  // ----------------------------------------------------------------
  logic       break_pulse;
  ulsr_char_t fifo_head;
  logic       fifo_empty;
  logic       fifo_full;

  // A break arrives as one all-zero character tagged as break.
  wire        arrive   = i_rx_valid | break_pulse;
  ulsr_char_t in_char;
  assign in_char = break_pulse ? ulsr_char_t'{brk: 1'b1, par_bad: 1'b0, data: 8'h00}
                               : ulsr_char_t'{brk: 1'b0, par_bad: i_rx_parity_bad, data: i_rx_data};

  wire buf_rd   = rd_done & hit_buf;
  wire lsr_rd   = rd_done & hit_lsr;
  wire fifo_pop = buf_rd & fifo_mode;
  // full FIFO refuses the new character
  wire fifo_push = arrive & fifo_mode & ~fifo_full;

  ulsr_rx_fifo #(
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_push    (fifo_push),
    .i_char    (in_char),
    .i_pop     (fifo_pop),
    .o_head    (fifo_head),
    .o_empty   (fifo_empty),
    .o_full    (fifo_full)
  );

  ulsr_break_det #(
    .LIMIT (BREAK_LIMIT)
  ) u_break (
    .i_ref_clk     (i_ref_clk),
    .i_arst_n      (i_arst_n),
    .i_rx_serial   (i_rx_serial),
    .o_break_pulse (break_pulse)
  );

  // ----------------------------------------------------------------
  // Flag sources
  // ----------------------------------------------------------------
  // head reveal
  wire        reveal      = fifo_mode & ~fifo_empty & ~head_shown_reg;
  wire        direct_load = arrive & ~fifo_mode;
  ulsr_char_t shown_char;
  assign shown_char = fifo_mode ? fifo_head : in_char;
  wire        shown       = fifo_mode ? reveal : direct_load;
  wire        pe_set      = shown & ((shown_char.par_bad & parity_en) | shown_char.brk);
  wire        brk_set     = shown & shown_char.brk;
  wire        ovr_direct  = direct_load & rbr_full_reg & ~buf_rd;
  wire        ovr_fifo    = arrive & fifo_mode & fifo_full;
  wire        ovr_set     = ovr_direct | ovr_fifo;

  // Clears act only on bits that the completed read actually returned, so an event
  // landing between capture and completion is never lost.
  wire        pe_clr      = lsr_rd & o_prdata[ULSR_LS_PARITY_BIT];
  wire        ovr_clr     = lsr_rd & o_prdata[ULSR_LS_OVERRUN_BIT];
  wire        brk_clr     = lsr_rd & o_prdata[ULSR_LS_BREAK_BIT];

  wire        parity_err_next = (parity_err_reg & ~pe_clr) | pe_set;
  wire        overrun_next    = (overrun_reg & ~ovr_clr) | ovr_set;
  wire        break_next      = (break_reg & ~brk_clr) | brk_set;
  // buffer read empties it unless a character lands at once
  wire        rbr_full_next   = (rbr_full_reg & ~buf_rd) | direct_load;
  // data available from buffer or FIFO
  wire        avail_now       = fifo_mode ? ~fifo_empty : rbr_full_reg;

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [ULSR_EV_WIDTH-1:0] events;
  assign events[ULSR_EV_ARRIVE_BIT]  = direct_load | fifo_push;
  assign events[ULSR_EV_OVERRUN_BIT] = ovr_set;
  assign events[ULSR_EV_PARITY_BIT]  = pe_set;
  assign events[ULSR_EV_BREAK_BIT]   = brk_set;

  wire [ULSR_EV_WIDTH-1:0] int_clr         = (wr_done & hit_icl) ? i_pwdata[ULSR_EV_WIDTH-1:0] : '0;
  wire [ULSR_EV_WIDTH-1:0] int_status_next = (int_status_reg & ~int_clr) | events;
  wire [ULSR_EV_WIDTH-1:0] int_enable_next =
    (wr_done & hit_ien) ? i_pwdata[ULSR_EV_WIDTH-1:0] : int_enable_reg;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // upper bits read zero
  wire [31:0] lsr_word = {27'h0, break_reg, 1'b0, parity_err_reg, overrun_reg, avail_now};
  wire [7:0]  buf_byte = fifo_mode ? fifo_head.data : rbr_reg.data;
  wire [31:0] rd_mux   =
    hit_buf ? {24'h0, buf_byte} :
    hit_ctl ? {30'h0, control_reg} :
    hit_ist ? {28'h0, int_status_reg} :
    hit_ien ? {28'h0, int_enable_reg} :
    hit_lsr ? lsr_word :
    hit_spr ? {24'h0, spare_reg} : ULSR_ZERO_WORD;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= ULSR_ZERO_WORD;
    end else begin
      o_pready  <= pready_next;
      o_pslverr <= pready_next & ~hit_any;
      if (pready_next && !i_pwrite) begin
        o_prdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      control_reg <= ULSR_CONTROL_RESET;
      spare_reg   <= ULSR_SPARE_RESET;
    end else begin
      if (wr_done && hit_ctl) control_reg <= i_pwdata[1:0];
      if (wr_done && hit_spr) spare_reg <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rbr_reg      <= '0;
      rbr_full_reg <= 1'b0;
    end else begin
      if (direct_load) rbr_reg <= in_char;
      rbr_full_reg <= rbr_full_next;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      parity_err_reg <= 1'b0;
      overrun_reg    <= 1'b0;
      break_reg      <= 1'b0;
      head_shown_reg <= 1'b0;
    end else begin
      parity_err_reg <= parity_err_next;
      overrun_reg    <= overrun_next;
      break_reg      <= break_next;
      head_shown_reg <= fifo_pop ? 1'b0 : (head_shown_reg | reveal);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      int_status_reg   <= '0;
      int_enable_reg   <= '0;
      o_irq            <= 1'b0;
      o_data_available <= 1'b0;
    end else begin
      int_status_reg   <= int_status_next;
      int_enable_reg   <= int_enable_next;
      o_irq            <= |(int_status_next & int_enable_next);
      o_data_available <= avail_now;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_lsr_read;
    access ##1 (access && o_pready && !i_pwrite && hit_lsr);
  endsequence

  a_pe_sets_flag: assert property (pe_set |=> parity_err_reg)
    else $error("parity error event did not set the flag");

  a_pe_at_head: assert property ($rose(parity_err_reg) && $past(fifo_mode) |-> $past(reveal))
    else $error("parity error shown before the character reached the FIFO head");

  a_break_to_pe: assert property (brk_set |=> parity_err_reg && break_reg)
    else $error("break did not set parity error and break flags");

  a_pe_read_clear: assert property (s_lsr_read ##0 (o_prdata[ULSR_LS_PARITY_BIT] && !pe_set)
                                    |=> !parity_err_reg)
    else $error("line status read did not clear parity error");

  a_ovr_direct: assert property (direct_load && rbr_full_reg && !buf_rd
                                 |=> overrun_reg && rbr_reg == $past(in_char))
    else $error("buffer overrun not flagged or buffer not overwritten");

  a_ovr_fifo_keep: assert property (ovr_fifo && !fifo_pop |=> overrun_reg && fifo_full && $stable(fifo_head))
    else $error("FIFO overrun altered FIFO contents or missed the flag");

  a_ovr_read_clear: assert property (s_lsr_read ##0 (o_prdata[ULSR_LS_OVERRUN_BIT] && !ovr_set)
                                     |=> !overrun_reg)
    else $error("line status read did not clear overrun");

  // buffer read empties in direct mode
  a_da_clear: assert property (buf_rd && !fifo_mode && !arrive && !$past(fifo_mode)
                               |=> ##1 !o_data_available)
    else $error("data available stayed set after buffer read");

  a_spare_write: assert property (wr_done && hit_spr |=> (spare_reg == $past(i_pwdata[7:0]))
                                  ##1 (spare_reg == $past(i_pwdata[7:0], 2)))
    else $error("spare storage byte lost the written value");

endmodule // ulsr_status

// ==== pkg/ulsr_pkg.sv ====
// Package with register map, field layout, reset values and timing constants of the receive status block.
package ulsr_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ULSR_RX_BUFFER_ADDR  = 32'h5000_1100;
  localparam logic [31:0] ULSR_CONTROL_ADDR    = 32'h5000_1104;
  localparam logic [31:0] ULSR_INT_STATUS_ADDR = 32'h5000_1108;
  localparam logic [31:0] ULSR_INT_CLEAR_ADDR  = 32'h5000_110C;
  localparam logic [31:0] ULSR_INT_ENABLE_ADDR = 32'h5000_1110;
  localparam logic [31:0] ULSR_LINE_STAT_ADDR  = 32'h5000_1114;
  localparam logic [31:0] ULSR_SPARE_ADDR      = 32'h5000_111C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ULSR_LS_DATA_AVAIL_BIT = 0;
  localparam int ULSR_LS_OVERRUN_BIT    = 1;
  localparam int ULSR_LS_PARITY_BIT     = 2;
  localparam int ULSR_LS_BREAK_BIT      = 4;
  localparam int ULSR_CTL_PARITY_EN_BIT = 0;
  localparam int ULSR_CTL_FIFO_EN_BIT   = 1;
  localparam int ULSR_EV_ARRIVE_BIT     = 0;
  localparam int ULSR_EV_OVERRUN_BIT    = 1;
  localparam int ULSR_EV_PARITY_BIT     = 2;
  localparam int ULSR_EV_BREAK_BIT      = 3;
  localparam int ULSR_EV_WIDTH          = 4;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0]  ULSR_SPARE_RESET   = 8'h00;
  localparam logic [1:0]  ULSR_CONTROL_RESET = 2'h0;
  localparam logic [31:0] ULSR_ZERO_WORD     = 32'h0000_0000;
  localparam int          ULSR_FIFO_DEPTH    = 16;

  // ----------------------------------------------------------------
  // Timing: bit time and character length for break detection
  // ----------------------------------------------------------------
  localparam int ULSR_CLK_HZ      = 20_000_000;
  localparam int ULSR_BAUD        = 115_200;
  localparam int ULSR_BIT_CYCLES  = ULSR_CLK_HZ / ULSR_BAUD;
  localparam int ULSR_CHAR_BITS   = 11;
  localparam int ULSR_BREAK_LIMIT = ULSR_BIT_CYCLES * ULSR_CHAR_BITS;

  // One received character with its error tags.
  typedef struct packed {
    logic       brk;
    logic       par_bad;
    logic [7:0] data;
  } ulsr_char_t;

endpackage

// ==== src/ulsr_rx_fifo.sv ====
// Receive FIFO holding characters with their error tags.
`timescale 1ns/100ps
module ulsr_rx_fifo
  import ulsr_pkg::*;
#(
  parameter int DEPTH = ULSR_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_arst_n,
  // Fill side
  input  wire logic       i_push,
  input  wire ulsr_char_t i_char,
  // Drain side
  input  wire logic       i_pop,
  output ulsr_char_t      o_head,
  output logic            o_empty,
  output logic            o_full
);
  localparam int AW = $clog2(DEPTH);

  ulsr_char_t            mem [DEPTH];
  logic [AW-1:0]         wr_ptr_reg;
  logic [AW-1:0]         rd_ptr_reg;
  logic [AW:0]           count_reg;

  wire do_push = i_push & ~o_full;
  wire do_pop  = i_pop & ~o_empty;

  assign o_empty = (count_reg == '0);
  assign o_full  = (count_reg == (AW+1)'(DEPTH));
  assign o_head  = mem[rd_ptr_reg];

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge i_ref_clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= i_char;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (do_pop)  rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule // ulsr_rx_fifo

// ==== src/ulsr_break_det.sv ====
// Break detector: one pulse when the serial input stays low past one character time.
`timescale 1ns/100ps
module ulsr_break_det
  import ulsr_pkg::*;
#(
  parameter int LIMIT = ULSR_BREAK_LIMIT
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_arst_n,
  // Serial line
  input  wire logic i_rx_serial,
  // Detection
  output logic      o_break_pulse
);
  localparam int CW = $clog2(LIMIT + 2);

  logic [CW-1:0] low_cnt_reg;
  logic          fired_reg;

  // A break reports once; the line must go high before the next one counts.
  wire at_limit = (low_cnt_reg == CW'(LIMIT));

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_cnt_reg   <= '0;
      fired_reg     <= 1'b0;
      o_break_pulse <= 1'b0;
    end else begin
      o_break_pulse <= 1'b0;
      if (i_rx_serial) begin
        low_cnt_reg <= '0;
        fired_reg   <= 1'b0;
      end else if (!at_limit) begin
        low_cnt_reg <= low_cnt_reg + 1'b1;
      end else if (!fired_reg) begin
        o_break_pulse <= 1'b1;
        fired_reg     <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  a_break_needs_low: assert property (o_break_pulse |-> $past(!i_rx_serial) && at_limit)
    else $error("break pulse without a full low character time");
endmodule // ulsr_break_det

// ==== verif/ulsr_rx_model.sv ====
// Behavioural model of the remote transmitter and receive shifter feeding the status block.
`timescale 1ns/100ps
module ulsr_rx_model (
  // Clock
  input  wire logic  i_ref_clk,
  // Receive shifter side
  output logic       o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic       o_rx_parity_bad,
  output logic       o_rx_serial
);
  initial begin
    o_rx_valid      = 1'b0;
    o_rx_data       = 8'h00;
    o_rx_parity_bad = 1'b0;
    o_rx_serial     = 1'b1;
  end

  // One completed character, after an optional idle gap. The data lines do not keep
  // their value afterwards, so a design that samples them late sees the inverse.
  task automatic send_char(input logic [7:0] data, input logic bad, input int gap);
    repeat (gap) @(posedge i_ref_clk);
    @(posedge i_ref_clk);
    o_rx_valid      <= 1'b1;
    o_rx_data       <= data;
    o_rx_parity_bad <= bad;
    @(posedge i_ref_clk);
    o_rx_valid      <= 1'b0;
    o_rx_data       <= ~data;
    o_rx_parity_bad <= ~bad;
  endtask

  task automatic hold_low(input int cycles);
    @(posedge i_ref_clk);
    o_rx_serial <= 1'b0;
    repeat (cycles) @(posedge i_ref_clk);
    o_rx_serial <= 1'b1;
  endtask
endmodule // ulsr_rx_model

// ==== verif/ulsr_status_tb.sv ====
// Self-checking testbench of the receive line status block.
`timescale 1ns/100ps
module ulsr_status_tb
  import ulsr_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  localparam int BRK = 20;
  localparam logic [31:0] LS = ULSR_LINE_STAT_ADDR;
  localparam logic [31:0] RB = ULSR_RX_BUFFER_ADDR;

  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err_q;
  logic [31:0] paddr, pwdata, prdata, rd_q;
  logic        rx_valid, rx_parity_bad, rx_serial, data_avail, irq;
  logic [7:0]  rx_data;
  int          n_fail, samples_checked;

  ulsr_status #(.FIFO_DEPTH(4), .BREAK_LIMIT(BRK)) i_ulsr_status (
    .i_ref_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_parity_bad(rx_parity_bad),
    .i_rx_serial(rx_serial), .o_data_available(data_avail), .o_irq(irq));

  ulsr_rx_model i_ulsr_rx_model (
    .i_ref_clk(clk), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_rx_parity_bad(rx_parity_bad), .o_rx_serial(rx_serial));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  // Entered right after a rising edge; the request is held until pready is seen high.
  task automatic apb_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    int guard;
    guard = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && guard < 50) begin
      @(posedge clk);
      guard++;
    end
    if (guard >= 50) begin
      n_fail++;
      $display("unexpected wait at %0t: no ready", $time);
    end
    rd_q  = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    apb_xfer(1'b1, addr, data);
  endtask

  task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
    apb_xfer(1'b0, addr, 32'h0000_0000);
    chk(rd_q, exp);
  endtask

  task automatic rx(input logic [7:0] data, input logic bad);
    i_ulsr_rx_model.send_char(data, bad, 2);
    repeat (2) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (8000) @(posedge clk);
    n_fail++;
    conclude();
  end

  initial begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0000_0000; pwdata = 32'h0000_0000;
    n_fail = 0; samples_checked = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // Reset values, spare byte, read-only and unmapped places.
    rd(ULSR_SPARE_ADDR, 32'h0000_0000);
    rd(LS, 32'h0000_0000);
    wr(ULSR_SPARE_ADDR, 32'hFFFF_FFA5);
    rd(ULSR_SPARE_ADDR, 32'h0000_00A5);
    wr(LS, 32'hFFFF_FFFF);
    rd(LS, 32'h0000_0000);
    rd(32'h5000_1118, 32'h0000_0000);
    chk({31'h0, err_q}, 32'h0000_0001);
    rd(ULSR_SPARE_ADDR, 32'h0000_00A5);
    // Non-FIFO: arrival, overrun overwrite, clear on read.
    rx(8'h5A, 1'b0);
    rd(LS, 32'h0000_0001);
    chk({31'h0, data_avail}, 32'h0000_0001);
    rx(8'h3C, 1'b0);
    rd(LS, 32'h0000_0003);
    rd(LS, 32'h0000_0001);
    rd(RB, 32'h0000_003C);
    rd(LS, 32'h0000_0000);
    chk({31'h0, data_avail}, 32'h0000_0000);
    // Parity error ignored while checking is off, flagged when on.
    rx(8'hA1, 1'b1);
    rd(LS, 32'h0000_0001);
    rd(RB, 32'h0000_00A1);
    wr(ULSR_CONTROL_ADDR, 32'h0000_0001);
    rd(ULSR_CONTROL_ADDR, 32'h0000_0001);
    rx(8'hA2, 1'b1);
    rd(LS, 32'h0000_0005);
    rd(LS, 32'h0000_0001);
    rd(RB, 32'h0000_00A2);
    // A low shorter than a character is not a break; a longer one is.
    i_ulsr_rx_model.hold_low(BRK - 5);
    repeat (4) @(posedge clk);
    rd(LS, 32'h0000_0000);
    i_ulsr_rx_model.hold_low(BRK + 10);
    repeat (4) @(posedge clk);
    rd(LS, 32'h0000_0015);
    rd(LS, 32'h0000_0001);
    rd(RB, 32'h0000_0000);
    // FIFO mode: fill past full, parity revealed at the head only.
    wr(ULSR_CONTROL_ADDR, 32'h0000_0003);
    rx(8'h11, 1'b0);
    rx(8'h22, 1'b1);
    rx(8'h33, 1'b0);
    rx(8'h44, 1'b0);
    rx(8'h55, 1'b0);
    rd(LS, 32'h0000_0003);
    rd(LS, 32'h0000_0001);
    rd(RB, 32'h0000_0011);
    rd(LS, 32'h0000_0005);
    rd(RB, 32'h0000_0022);
    rd(RB, 32'h0000_0033);
    rd(RB, 32'h0000_0044);
    rd(LS, 32'h0000_0000);
    chk({31'h0, data_avail}, 32'h0000_0000);
    // Interrupt: raised only when enabled, dropped on clear.
    wr(ULSR_INT_CLEAR_ADDR, 32'h0000_000F);
    rd(ULSR_INT_STATUS_ADDR, 32'h0000_0000);
    rx(8'h66, 1'b0);
    rd(ULSR_INT_STATUS_ADDR, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(ULSR_INT_ENABLE_ADDR, 32'h0000_0001);
    rd(ULSR_INT_ENABLE_ADDR, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(ULSR_INT_CLEAR_ADDR, 32'h0000_0001);
    rd(ULSR_INT_STATUS_ADDR, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(RB, 32'h0000_0066);
    rd(ULSR_SPARE_ADDR, 32'h0000_00A5);
    conclude();
  end
endmodule // ulsr_status_tb
